// *** design/brs_pkg.sv ***
`default_nettype none

package brs_pkg;

    // -------------------------------------------------------------------
    // Sizes.
    // -------------------------------------------------------------------
    localparam int unsigned STACK_DEPTH = 32; // Entries in the record stack.
    localparam int unsigned WORD_W = 64; // Width of every register word.
    localparam int unsigned ADDR_W = 8; // Width of the register index.
    localparam int unsigned STORE_DEPTH = 1024; // Records held by the store buffer.

    // -------------------------------------------------------------------
    // Register indices.
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_CAP = 8'h00; // Performance capability, read only.
    localparam logic [7:0] REG_DBGCTL = 8'h01; // Trace debug control.
    localparam logic [7:0] REG_TOP = 8'h02; // Stack top index.
    localparam logic [7:0] REG_GSTAT = 8'h03; // Global counter status, read only.
    localparam logic [7:0] REG_GCLR = 8'h04; // Global status clear, write only.
    localparam logic [7:0] REG_EXC_SRC = 8'h05; // Last exception record source.
    localparam logic [7:0] REG_EXC_DST = 8'h06; // Last exception record target.
    localparam logic [7:0] REG_SRC_BASE = 8'h40; // Branch source entries.
    localparam logic [7:0] REG_DST_BASE = 8'h60; // Branch target entries.
    localparam logic [7:0] REG_INFO_BASE = 8'h80; // Branch information entries.

    // -------------------------------------------------------------------
    // Field positions and reset values.
    // -------------------------------------------------------------------
    localparam logic [5:0] FORMAT_CODE = 6'h05; // Three-word record layout code.
    localparam int unsigned CTL_REC = 0; // Record enable.
    localparam int unsigned CTL_BTF = 1; // Step on branches.
    localparam int unsigned CTL_TR = 2; // Trace message enable.
    localparam int unsigned CTL_STORE = 3; // Trace store enable.
    localparam int unsigned CTL_FULLINT = 4; // Buffer full interrupt.
    localparam int unsigned CTL_SKIP_K = 5; // Skip kernel trace.
    localparam int unsigned CTL_SKIP_U = 6; // Skip user trace.
    localparam int unsigned CTL_W = 7; // Implemented control bits.
    localparam logic [6:0] CTL_RESET = 7'h00; // Control reset value.
    localparam int unsigned GSTAT_FRZ = 58; // Freeze status bit position.
    localparam int unsigned CYC_W = 16; // Cycle count field width.
    localparam int unsigned INFO_ABORT = 61; // Abort entry flag.
    localparam int unsigned INFO_TXN = 62; // In-transaction flag.
    localparam int unsigned INFO_MISP = 63; // Mispredict flag.

endpackage

`default_nettype wire

// *** design/stack_mem_if.sv ***
`default_nettype none

// ---------------------------------------------------------------------------
// Link between the recorder control and its entry memory.
// ---------------------------------------------------------------------------
interface stack_mem_if #(
    parameter int unsigned IDX_W = 5
);
    logic clear; // Zero every entry this cycle.
    logic [2:0] wen; // Word enables: source, target, information.
    logic [IDX_W-1:0] waddr; // Entry written.
    logic [63:0] wsrc; // Source word to write.
    logic [63:0] wdst; // Target word to write.
    logic [63:0] winfo; // Information word to write.
    logic [IDX_W-1:0] raddr; // Entry read.
    logic [63:0] rsrc; // Registered source word.
    logic [63:0] rdst; // Registered target word.
    logic [63:0] rinfo; // Registered information word.

    modport ctrl (output clear, wen, waddr, wsrc, wdst, winfo, raddr, input rsrc, rdst, rinfo);
    modport mem (input clear, wen, waddr, wsrc, wdst, winfo, raddr, output rsrc, rdst, rinfo);
endinterface

`default_nettype wire

// *** design/brs_stack_mem.sv ***
`default_nettype none

// ---------------------------------------------------------------------------
// Entry memory: three words per entry, registered read.
// ---------------------------------------------------------------------------
module brs_stack_mem #(
    parameter int unsigned DEPTH = brs_pkg::STACK_DEPTH
) (
    input wire logic clk_i, // Core clock.
    input wire logic rst_i, // Synchronous reset, high.
    stack_mem_if.mem mp // Control side.
);
    logic [63:0] src_q [DEPTH]; // Source words.
    logic [63:0] dst_q [DEPTH]; // Target words.
    logic [63:0] info_q [DEPTH]; // Information words.

    // Writes and clear; clear covers reset and deep sleep zeroing.
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (rst_i || mp.clear) begin
                src_q[i] <= 64'h0;
                dst_q[i] <= 64'h0;
                info_q[i] <= 64'h0;
            end else if (mp.waddr == i[$bits(mp.waddr)-1:0]) begin
                if (mp.wen[0]) src_q[i] <= mp.wsrc;
                if (mp.wen[1]) dst_q[i] <= mp.wdst;
                if (mp.wen[2]) info_q[i] <= mp.winfo;
            end
        end
    end

    // Read data come from a register, one cycle after the address.
    always_ff @(posedge clk_i) begin
        mp.rsrc <= src_q[mp.raddr];
        mp.rdst <= dst_q[mp.raddr];
        mp.rinfo <= info_q[mp.raddr];
    end
endmodule

`default_nettype wire

// *** design/branch_record_stack.sv ***
`default_nettype none

module branch_record_stack #(
    parameter int unsigned DEPTH = brs_pkg::STACK_DEPTH, // Stack entries.
    parameter int unsigned STORE_DEPTH = brs_pkg::STORE_DEPTH // Store buffer records.
) (
    input wire logic CORE_CLK_I, // Core clock.
    input wire logic SYS_RST_I, // Synchronous reset, high.
    input wire logic BR_VALID_I, // Branch, interrupt or exception retired.
    input wire logic BR_EXC_I, // Retired event is an interrupt or exception.
    input wire logic [63:0] BR_SRC_I, // Source address.
    input wire logic [63:0] BR_DST_I, // Target address.
    input wire logic BR_MISPREDICT_FLAG_I, // Target or direction mispredicted.
    input wire logic BR_IN_TXN_I, // Inside a transaction region.
    input wire logic BR_ABORT_I, // Transaction abort entry.
    input wire logic [1:0] BR_CPL_I, // Privilege level of the event.
    input wire logic INSN_RETIRE_I, // Any instruction retired.
    input wire logic TRAP_FLAG_I, // Core trap flag.
    input wire logic DBG_EXC_I, // Debug exception raised.
    input wire logic CNT_IRQ_REQ_I, // Counter overflow interrupt request.
    input wire logic SLEEP_REQ_I, // Deep sleep request pulse.
    input wire logic SLEEP_ZERO_I, // Chosen waiting state loses state.
    input wire logic REG_REQ_I, // Register access request.
    input wire logic REG_WE_I, // Access is a write.
    input wire logic [7:0] REG_ADDR_I, // Register index.
    input wire logic [63:0] REG_WDATA_I, // Write data.
    input wire logic [1:0] REG_CPL_I, // Privilege of the accessing code.
    input wire logic REG_REAL_I, // Accessing code in real-address mode.
    output logic REG_ACK_O, // Access done, one-cycle pulse.
    output logic [63:0] REG_RDATA_O, // Read data, valid with the ack.
    output logic SSTEP_TRAP_O, // Single-step trap request pulse.
    output logic TRACE_MSG_VALID_O, // Branch trace message pulse.
    output logic [63:0] TRACE_MSG_SRC_O, // Message source address.
    output logic [63:0] TRACE_MSG_DST_O, // Message target address.
    output logic STORE_VALID_O, // Store one message into the buffer.
    output logic [$clog2(STORE_DEPTH)-1:0] STORE_IDX_O, // Buffer slot of that message.
    output logic STORE_FULL_INT_O // Buffer full interrupt pulse.
);
    localparam int unsigned IDX_W = $clog2(DEPTH);
    localparam int unsigned SIDX_W = $clog2(STORE_DEPTH);

    // -------------------------------------------------------------------
    // Elaboration checks.
    // -------------------------------------------------------------------
    if (DEPTH < 2 || DEPTH > 32 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
        $error("DEPTH must be a power of two from 2 to 32.");
    end
    if (STORE_DEPTH < 2 || (STORE_DEPTH & (STORE_DEPTH - 1)) != 0) begin : g_store_chk
        $error("STORE_DEPTH must be a power of two of at least 2.");
    end

    // Entry field decode, shared by the three entry windows.
    function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
        in_window = (a[7:5] == base[7:5]) && ({3'h0, a[4:0]} < 8'(DEPTH));
    endfunction

    // -------------------------------------------------------------------
    // State.
    // -------------------------------------------------------------------
    stack_mem_if #(.IDX_W(IDX_W)) mif ();
    logic [brs_pkg::CTL_W-1:0] ctl_q; // Trace debug control bits.
    logic frz_q; // Record freeze status.
    logic [IDX_W-1:0] top_q; // Stack top index.
    logic [brs_pkg::CYC_W-1:0] cyc_q; // Cycles since last stack update.
    logic first_q; // Next record follows a deep sleep.
    logic [63:0] last_src_q; // Newest branch source.
    logic [63:0] last_dst_q; // Newest branch target.
    logic [63:0] exc_src_q; // Last exception record source.
    logic [63:0] exc_dst_q; // Last exception record target.
    logic [SIDX_W-1:0] sidx_q; // Next store buffer slot.
    logic shalt_q; // Store stopped on a full buffer.
    logic pend_q; // Access in its second cycle.
    logic [7:0] addr_q; // Address of that access.
    logic sstep_q; // Registered step trap.
    logic msg_q; // Registered message strobe.
    logic [63:0] msg_src_q; // Message source.
    logic [63:0] msg_dst_q; // Message target.
    logic store_q; // Registered store strobe.
    logic [SIDX_W-1:0] store_idx_q; // Registered store slot.
    logic full_q; // Registered full interrupt.
    logic ack_q; // Access ack.
    logic [63:0] rdata_q; // Read data register.

    // -------------------------------------------------------------------
    // Decode.
    // -------------------------------------------------------------------
    wire logic take = REG_REQ_I && !pend_q && !ack_q; // One access at a time.
    wire logic wr = take && REG_WE_I;
    wire logic priv_ok = (REG_CPL_I == 2'h0) || REG_REAL_I;
    wire logic ctl_wr = wr && (REG_ADDR_I == brs_pkg::REG_DBGCTL) && priv_ok;
    wire logic top_wr = wr && (REG_ADDR_I == brs_pkg::REG_TOP);
    wire logic clr_wr = wr && (REG_ADDR_I == brs_pkg::REG_GCLR);
    wire logic exs_wr = wr && (REG_ADDR_I == brs_pkg::REG_EXC_SRC);
    wire logic exd_wr = wr && (REG_ADDR_I == brs_pkg::REG_EXC_DST);
    wire logic [2:0] ent_wr = {3{wr}} & {in_window(REG_ADDR_I, brs_pkg::REG_INFO_BASE),
        in_window(REG_ADDR_I, brs_pkg::REG_DST_BASE), in_window(REG_ADDR_I, brs_pkg::REG_SRC_BASE)};
    wire logic zero = SLEEP_REQ_I && SLEEP_ZERO_I;
    // A record is taken only while enabled and not frozen.
    wire logic rec = BR_VALID_I && ctl_q[brs_pkg::CTL_REC] && !frz_q && !zero;
    wire logic [IDX_W-1:0] top_nx = IDX_W'(top_q + 1'b1);
    // Privilege filter for messages and store.
    wire logic allow = (BR_CPL_I == 2'h0) ? !ctl_q[brs_pkg::CTL_SKIP_K] : !ctl_q[brs_pkg::CTL_SKIP_U];
    wire logic msg = BR_VALID_I && ctl_q[brs_pkg::CTL_TR] && allow;
    wire logic sto = BR_VALID_I && ctl_q[brs_pkg::CTL_STORE] && allow && !shalt_q;
    wire logic sfull = sto && (sidx_q == SIDX_W'(STORE_DEPTH - 1));
    wire logic [brs_pkg::CYC_W-1:0] cyc_rec = first_q ? '0 : cyc_q;
    wire logic [63:0] info_w = {BR_MISPREDICT_FLAG_I, BR_IN_TXN_I, BR_ABORT_I,
        45'h0, cyc_rec};

    // -------------------------------------------------------------------
    // Memory port: a record owns the write port; a software entry write in
    // the same cycle is dropped, which keeps one write port on the array.
    // -------------------------------------------------------------------
    assign mif.clear = zero;
    assign mif.wen = rec ? 3'h7 : ent_wr;
    assign mif.waddr = rec ? top_nx : REG_ADDR_I[IDX_W-1:0];
    assign mif.wsrc = rec ? BR_SRC_I : REG_WDATA_I;
    assign mif.wdst = rec ? BR_DST_I : REG_WDATA_I;
    assign mif.winfo = rec ? info_w : REG_WDATA_I;
    assign mif.raddr = REG_ADDR_I[IDX_W-1:0];

    brs_stack_mem #(.DEPTH(DEPTH)) u_mem (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .mp(mif.mem)
    );

    // -------------------------------------------------------------------
    // Control register; a debug exception wins over a software write.
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ctl_q <= brs_pkg::CTL_RESET;
        end else if (DBG_EXC_I) begin
            ctl_q <= ctl_q & ~brs_pkg::CTL_W'(1);
        end else if (ctl_wr) begin
            ctl_q <= REG_WDATA_I[brs_pkg::CTL_W-1:0];
        end
    end

    // Freeze: a request in the clear cycle keeps the bit set.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            frz_q <= 1'b0;
        end else if (CNT_IRQ_REQ_I) begin
            frz_q <= 1'b1;
        end else if (clr_wr && REG_WDATA_I[brs_pkg::GSTAT_FRZ]) begin
            frz_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Top index and cycle counter.
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || zero) begin
            top_q <= '0;
        end else if (rec) begin
            top_q <= top_nx;
        end else if (top_wr) begin
            top_q <= REG_WDATA_I[IDX_W-1:0];
        end
    end

    // The counter saturates instead of wrapping, so a long gap reads as max.
    // The record edge itself is the first elapsed clock of the next gap.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            cyc_q <= '0;
        end else if (rec) begin
            cyc_q <= {{(brs_pkg::CYC_W-1){1'b0}}, 1'b1};
        end else if (cyc_q != '1) begin
            cyc_q <= cyc_q + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            first_q <= 1'b0;
        end else if (SLEEP_REQ_I) begin
            first_q <= 1'b1;
        end else if (rec) begin
            first_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Last exception record: the branch taken before an exception.
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || zero) begin
            last_src_q <= 64'h0;
            last_dst_q <= 64'h0;
            exc_src_q <= 64'h0;
            exc_dst_q <= 64'h0;
        end else begin
            if (rec) begin
                last_src_q <= BR_SRC_I;
                last_dst_q <= BR_DST_I;
            end
            if (rec && BR_EXC_I) begin
                exc_src_q <= last_src_q;
                exc_dst_q <= last_dst_q;
            end else begin
                if (exs_wr) exc_src_q <= REG_WDATA_I;
                if (exd_wr) exc_dst_q <= REG_WDATA_I;
            end
        end
    end

    // -------------------------------------------------------------------
    // Store buffer slot: stop and interrupt, or wrap. Writing the control
    // register restarts the buffer at slot zero.
    // -------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || ctl_wr) begin
            sidx_q <= '0;
            shalt_q <= 1'b0;
        end else if (sto) begin
            sidx_q <= SIDX_W'(sidx_q + 1'b1);
            shalt_q <= sfull && ctl_q[brs_pkg::CTL_FULLINT];
        end
    end

    // Registered strobes toward the core, the trace port and the buffer.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            sstep_q <= 1'b0;
            msg_q <= 1'b0;
            msg_src_q <= 64'h0;
            msg_dst_q <= 64'h0;
            store_q <= 1'b0;
            store_idx_q <= '0;
            full_q <= 1'b0;
        end else begin
            sstep_q <= TRAP_FLAG_I && (ctl_q[brs_pkg::CTL_BTF] ? BR_VALID_I : INSN_RETIRE_I);
            msg_q <= msg;
            msg_src_q <= msg ? BR_SRC_I : msg_src_q;
            msg_dst_q <= msg ? BR_DST_I : msg_dst_q;
            store_q <= sto;
            store_idx_q <= sto ? sidx_q : store_idx_q;
            full_q <= sfull && ctl_q[brs_pkg::CTL_FULLINT];
        end
    end

    // -------------------------------------------------------------------
    // Register read path: address in cycle 0, memory word in cycle 1,
    // read data and ack registered into cycle 2.
    // -------------------------------------------------------------------
    wire logic [63:0] rd_mux =
        (addr_q == brs_pkg::REG_CAP) ? {58'h0, brs_pkg::FORMAT_CODE} :
        (addr_q == brs_pkg::REG_DBGCTL) ? 64'(ctl_q) :
        (addr_q == brs_pkg::REG_TOP) ? 64'(top_q) :
        (addr_q == brs_pkg::REG_GSTAT) ? 64'(frz_q) << brs_pkg::GSTAT_FRZ :
        (addr_q == brs_pkg::REG_EXC_SRC) ? exc_src_q :
        (addr_q == brs_pkg::REG_EXC_DST) ? exc_dst_q :
        in_window(addr_q, brs_pkg::REG_SRC_BASE) ? mif.rsrc :
        in_window(addr_q, brs_pkg::REG_DST_BASE) ? mif.rdst :
        in_window(addr_q, brs_pkg::REG_INFO_BASE) ? mif.rinfo : 64'h0;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            pend_q <= 1'b0;
            addr_q <= 8'h00;
            ack_q <= 1'b0;
            rdata_q <= 64'h0;
        end else begin
            pend_q <= take;
            addr_q <= take ? REG_ADDR_I : addr_q;
            ack_q <= pend_q;
            rdata_q <= pend_q ? rd_mux : rdata_q;
        end
    end

    assign REG_ACK_O = ack_q;
    assign REG_RDATA_O = rdata_q;
    assign SSTEP_TRAP_O = sstep_q;
    assign TRACE_MSG_VALID_O = msg_q;
    assign TRACE_MSG_SRC_O = msg_src_q;
    assign TRACE_MSG_DST_O = msg_dst_q;
    assign STORE_VALID_O = store_q;
    assign STORE_IDX_O = store_idx_q;
    assign STORE_FULL_INT_O = full_q;

    // -------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------
    a_freeze_on_request: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        CNT_IRQ_REQ_I |=> frz_q) else $error("Freeze not set by counter request.");
    a_freeze_holds_top: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        frz_q && !top_wr && !zero |=> top_q == $past(top_q)) else $error("Top moved while frozen.");
    a_clear_freeze: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        clr_wr && REG_WDATA_I[brs_pkg::GSTAT_FRZ] && !CNT_IRQ_REQ_I |=> !frz_q)
        else $error("Freeze not cleared by write of one.");
    a_top_wraps: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        rec |=> top_q == IDX_W'($past(top_q) + 1'b1)) else $error("Top did not advance by one.");
    a_debug_disables: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        DBG_EXC_I |=> !ctl_q[brs_pkg::CTL_REC] && !rec)
        else $error("Record enable survived a debug exception.");
    a_sleep_keeps: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        SLEEP_REQ_I && !DBG_EXC_I && !ctl_wr && !CNT_IRQ_REQ_I && !clr_wr
        |=> $stable(ctl_q) && $stable(frz_q)) else $error("Deep sleep changed enable or freeze.");
    a_first_zero: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        first_q && rec |-> mif.winfo[brs_pkg::CYC_W-1:0] == '0) else $error("First record cycles not zero.");
    a_info_flags: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        rec |-> mif.winfo[brs_pkg::INFO_MISP] == BR_MISPREDICT_FLAG_I && mif.winfo[brs_pkg::INFO_TXN] == BR_IN_TXN_I)
        else $error("Information flags wrong.");
    a_skip_kernel: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        BR_VALID_I && BR_CPL_I == 2'h0 && ctl_q[brs_pkg::CTL_SKIP_K] |=> !TRACE_MSG_VALID_O && !STORE_VALID_O)
        else $error("Kernel message not skipped.");
    a_ctl_priv: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        wr && REG_ADDR_I == brs_pkg::REG_DBGCTL && REG_CPL_I != 2'h0 && !REG_REAL_I && !DBG_EXC_I
        |=> $stable(ctl_q)) else $error("Unprivileged control write taken.");
    a_ack_timing: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        take |-> ##1 !REG_ACK_O ##1 REG_ACK_O) else $error("Ack not two cycles after request.");
endmodule

`default_nettype wire

// *** verif/core_model.sv ***
`default_nettype none
// Core side: retires one branch per request; idle address lines toggle so stale values never pass.
module core_model (
    input wire logic clk_i, // Core clock.
    input wire logic fire_i, // Retire a branch.
    input wire logic [63:0] pc_i, // Branch source.
    output logic valid_o, // Branch retired.
    output logic [63:0] src_o, // Source.
    output logic [63:0] dst_o, // Target.
    output logic [5:0] flg_o // Exception, level, mispredict, region, abort.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        src_o = 64'h0;
        dst_o = 64'h0;
    end
    // Changes just after the rising edge, held one cycle.
    always @(posedge clk_i) begin
        valid_o <= fire_i;
        src_o <= fire_i ? pc_i : ~src_o;
        dst_o <= fire_i ? pc_i + 64'h10 : ~dst_o;
        flg_o <= pc_i[6:1];
    end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, fire = 0, dbg = 0, irq = 0, req = 0, we = 0, ack, vld;
    logic ret = 0, trap = 0, slp = 0, slz = 0, rl = 0, sst, msg_v, sto_v, full_v;
    logic [1:0] cpl = 2'h0, sidx, slot = 2'h0;
    logic [63:0] msg_s, msg_d;
    logic [7:0] adr = 8'h00;
    logic [63:0] wd = 64'h0, rd, pc = 64'h0, src, dst;
    logic [5:0] flg;
    logic [15:0] lfsr = 16'hE279;
    int fail_count = 0, checks_done = 0;
    always #4 clk = ~clk;
    core_model core_u (.clk_i(clk), .fire_i(fire), .pc_i(pc), .valid_o(vld), .src_o(src), .dst_o(dst), .flg_o(flg));
    branch_record_stack #(.DEPTH(4), .STORE_DEPTH(4)) dut_u (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .BR_VALID_I(vld), .BR_EXC_I(flg[5]), .BR_SRC_I(src), .BR_DST_I(dst), .BR_MISPREDICT_FLAG_I(flg[2]),
        .BR_IN_TXN_I(flg[1]), .BR_ABORT_I(flg[0]), .BR_CPL_I(flg[4:3]), .INSN_RETIRE_I(ret),
        .TRAP_FLAG_I(trap), .DBG_EXC_I(dbg), .CNT_IRQ_REQ_I(irq), .SLEEP_REQ_I(slp), .SLEEP_ZERO_I(slz),
        .REG_REQ_I(req), .REG_WE_I(we), .REG_ADDR_I(adr), .REG_WDATA_I(wd), .REG_CPL_I(cpl),
        .REG_REAL_I(rl), .REG_ACK_O(ack), .REG_RDATA_O(rd), .SSTEP_TRAP_O(sst), .TRACE_MSG_VALID_O(msg_v),
        .TRACE_MSG_SRC_O(msg_s), .TRACE_MSG_DST_O(msg_d), .STORE_VALID_O(sto_v), .STORE_IDX_O(sidx),
        .STORE_FULL_INT_O(full_v));
    // Sixteen-bit shift register for repeatable addresses.
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One register access; the request stands through the ack edge, and read data hold after it.
    task automatic acc(input logic w, input logic [7:0] a, input logic [63:0] d);
        int n;
        n = 0;
        @(negedge clk) {req, we, adr, wd} = {1'b1, w, a, d};
        // A privileged control write also restarts the store buffer at slot zero.
        if (w && a == 8'h01 && (cpl == 2'h0 || rl)) slot = 2'h0;
        do begin
            @(negedge clk) n++;
        end while (ack !== 1'b1 && n < 9);
        if (ack !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED t=%0t no ack", $time);
        end
        @(negedge clk) req = 0;
    endtask
    // One branch at level 0 or 1; e holds the expected message, store, full and step strobes.
    task automatic shot(input logic u, input logic [3:0] e);
        logic [63:0] p;
        lfsr = nxt(lfsr);
        p = {48'h0, lfsr[15:6], 1'b0, u, lfsr[3:0]};
        @(negedge clk) {fire, pc} = {1'b1, p};
        @(negedge clk) fire = 0;
        @(negedge clk) chk(msg_v, e[3]);
        chk(sto_v, e[2]);
        chk(full_v, e[1]);
        chk(sst, e[0]);
        if (e[3]) chk(msg_s, p);
        if (e[3]) chk(msg_d, p + 64'h10);
        if (e[2]) chk(sidx, slot);
        if (e[2]) slot++;
    endtask
    // Back-to-back branches with random sources.
    task automatic burst(input int k);
        repeat (k) begin
            @(negedge clk) fire = 1;
            lfsr = nxt(lfsr);
            pc = {48'h0, lfsr};
        end
        @(negedge clk) fire = 0;
        repeat (3) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000 fail_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        acc(0, 8'h00, 64'h0); chk(rd[5:0], 6'h05);
        acc(0, 8'h02, 64'h0); chk(rd, 64'h0);
        acc(1, 8'h01, 64'h1);
        burst(5);
        acc(0, 8'h02, 64'h0); chk(rd, 64'h1);
        acc(0, 8'h41, 64'h0); chk(rd, pc);
        acc(0, 8'h61, 64'h0); chk(rd, pc + 64'h10);
        acc(0, 8'h81, 64'h0); chk(rd, {pc[3:1], 45'h0, 16'h1});
        $display("record test done");
        @(negedge clk) irq = 1;
        @(negedge clk) irq = 0;
        acc(0, 8'h03, 64'h0); chk(rd[58], 1'b1);
        burst(2);
        acc(0, 8'h02, 64'h0); chk(rd, 64'h1);
        acc(1, 8'h04, 64'h1 << 58);
        acc(0, 8'h03, 64'h0); chk(rd[58], 1'b0);
        @(negedge clk) dbg = 1;
        @(negedge clk) dbg = 0;
        acc(0, 8'h01, 64'h0); chk(rd[0], 1'b0);
        $display("freeze test done");
        acc(1, 8'h01, 64'hC);
        repeat (5) shot(lfsr[0], 4'b1100);
        acc(1, 8'h01, 64'h2C);
        shot(0, 4'b0000);
        shot(1, 4'b1100);
        acc(1, 8'h01, 64'h4C);
        shot(1, 4'b0000);
        shot(0, 4'b1100);
        acc(1, 8'h01, 64'h1C);
        repeat (3) shot(0, 4'b1100);
        shot(1, 4'b1110);
        shot(0, 4'b1000);
        @(negedge clk) {trap, ret} = 2'b11;
        @(negedge clk) chk(sst, 1'b1);
        acc(1, 8'h01, 64'h2);
        chk(sst, 1'b0);
        shot(0, 4'b0001);
        @(negedge clk) {trap, ret} = 2'b00;
        $display("trace test done");
        @(negedge clk) cpl = 2'h3;
        acc(1, 8'h01, 64'h1);
        acc(0, 8'h01, 64'h0);
        chk(rd, 64'h2);
        @(negedge clk) rl = 1;
        acc(1, 8'h01, 64'h1);
        acc(0, 8'h01, 64'h0);
        chk(rd, 64'h1);
        @(negedge clk) {cpl, rl} = 3'h0;
        $display("privilege test done");
        acc(1, 8'h02, 64'h3);
        @(negedge clk) slp = 1;
        @(negedge clk) slp = 0;
        burst(1);
        acc(0, 8'h02, 64'h0);
        chk(rd, 64'h0);
        acc(0, 8'h80, 64'h0);
        chk(rd, {pc[3:1], 45'h0, 16'h0});
        acc(1, 8'h02, 64'h2);
        @(negedge clk) irq = 1;
        @(negedge clk) {irq, slp, slz} = 3'b011;
        @(negedge clk) {slp, slz} = 2'b00;
        acc(0, 8'h02, 64'h0);
        chk(rd, 64'h0);
        acc(0, 8'h40, 64'h0);
        chk(rd, 64'h0);
        acc(0, 8'h01, 64'h0);
        chk(rd[0], 1'b1);
        acc(0, 8'h03, 64'h0);
        chk(rd[58], 1'b1);
        $display("sleep test done");
        complete_run();
    end
endmodule
`default_nettype wire
